// >>> core/dpvd_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host controller for the dual-port buffer
// ****************************************
module dpvd_ctrl
  import dpvd_pkg::*;
#(
  parameter int unsigned PWRUP_CYC = DPVD_PWRUP_CYC,
  parameter int unsigned REF_INT_CYC = DPVD_REF_INT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire dpvd_req_t req, // request from user logic
  input wire logic req_valid, // request offered
  output logic req_ready_ff, // request taken this cycle
  output logic [DPVD_DW-1:0] rdata_ff, // read data
  output logic rdata_valid_ff, // one-cycle pulse
  output logic init_done_ff, // wake-up sequence finished
  input wire logic shift_run, // request serial shifting
  output logic [DPVD_DW-1:0] sdata_ff, // serial nibble
  output logic sdata_valid_ff, // one-cycle pulse
  output dpvd_pins_t pins_ff, // random port pins
  input wire logic [DPVD_DW-1:0] dq_i, // random data pins in
  output logic sc_out, // serial strobe pin
  output logic soe_n_ff, // serial output enable pin
  input wire logic [DPVD_DW-1:0] so_i // serial data pins
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [DPVD_DW-1:0] dq_m_ff, dq_s_ff, so_m_ff, so_s_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_m_ff <= '0;
      dq_s_ff <= '0;
      so_m_ff <= '0;
      so_s_ff <= '0;
    end else begin
      dq_m_ff <= dq_i;
      dq_s_ff <= dq_m_ff;
      so_m_ff <= so_i;
      so_s_ff <= so_m_ff;
    end
  end

  // serial port: outputs three-state by enable, held high until init is done and low after
  logic ser_active;
  logic sc_int;
  dpvd_serial #(.HALF(DPVD_SC_HALF_CYC)) u_ser (
    .clk(clk),
    .rst(rst),
    .run(shift_run & init_done_ff),
    .sdata_s(so_s_ff),
    .sc_ff(sc_int),
    .active_ff(ser_active),
    .nib_ff(sdata_ff),
    .nib_vld_ff(sdata_valid_ff)
  );
  assign sc_out = sc_int;

  // ****************************************
  // cycle sequencer
  // ****************************************
  typedef enum {
    DPVD_S_PWRUP, DPVD_S_IDLE, DPVD_S_RAS, DPVD_S_CAS, DPVD_S_LATE, DPVD_S_XEND, DPVD_S_PRE
  } dpvd_state_t;

  dpvd_state_t st_ff, nxt_st;
  logic [15:0] tmr_ff, nxt_tmr; // phase timer
  logic [15:0] ref_tmr_ff, nxt_ref_tmr; // refresh interval timer
  logic [DPVD_AW-1:0] ref_row_ff, nxt_ref_row; // next row to refresh
  logic ref_due_ff, nxt_ref_due;
  logic [3:0] init_cnt_ff, nxt_init_cnt;
  dpvd_req_t cur_ff, nxt_cur;
  dpvd_pins_t nxt_pins;
  logic nxt_ready, nxt_rvld, nxt_init;
  logic [DPVD_DW-1:0] nxt_rdata;

  // count helper used by every timed phase except the ras-to-cas step of user cycles
  function automatic logic tdone(input logic [15:0] t, input int unsigned n);
    tdone = (t >= 16'(n - 1));
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff + 16'h0001;
    nxt_ref_tmr = ref_tmr_ff;
    nxt_ref_row = ref_row_ff;
    nxt_ref_due = ref_due_ff;
    nxt_init_cnt = init_cnt_ff;
    nxt_cur = cur_ff;
    nxt_pins = pins_ff;
    nxt_ready = 1'b0;
    nxt_rvld = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_init = init_done_ff;
    case (st_ff)
      DPVD_S_PWRUP: begin
        // pause then eight ras-only cycles, never cas first
        if (tdone(tmr_ff, PWRUP_CYC)) begin
          nxt_cur = '{op: DPVD_OP_REFRESH, row: ref_row_ff, col: '0, wdata: '0, mask: '0, use_mask: 1'b0};
          nxt_st = DPVD_S_RAS;
          nxt_tmr = 16'h0000;
          nxt_pins.addr = ref_row_ff;
        end
      end
      DPVD_S_IDLE: begin
        nxt_tmr = 16'h0000;
        // refresh wins over user requests so the window is never missed
        if (ref_due_ff) begin
          nxt_ref_due = 1'b0;
          nxt_cur = '{op: DPVD_OP_REFRESH, row: ref_row_ff, col: '0, wdata: '0, mask: '0, use_mask: 1'b0};
          nxt_pins.addr = ref_row_ff;
          nxt_st = DPVD_S_RAS;
        end else if (req_valid) begin
          nxt_ready = 1'b1;
          nxt_cur = req;
          nxt_pins.addr = req.row;
          // strap levels set before ras falls
          nxt_pins.tr_oe_n = (req.op != DPVD_OP_XFER);
          nxt_pins.we_n = ~((req.op == DPVD_OP_WRITE) & req.use_mask);
          nxt_pins.dq_o = req.mask;
          nxt_pins.dq_oe = (req.op == DPVD_OP_WRITE) & req.use_mask;
          nxt_st = DPVD_S_RAS;
        end
      end
      DPVD_S_RAS: begin
        nxt_pins.ras_n = 1'b0;
        if (tmr_ff == 16'h0001) begin
          // row held, release straps then present column
          nxt_pins.we_n = ~(cur_ff.op == DPVD_OP_WRITE);
          nxt_pins.tr_oe_n = (cur_ff.op == DPVD_OP_XFER) ? 1'b0 : (cur_ff.op == DPVD_OP_WRITE);
          nxt_pins.dq_o = cur_ff.wdata;
          nxt_pins.dq_oe = (cur_ff.op == DPVD_OP_WRITE);
          nxt_pins.addr = cur_ff.col;
        end
        if (cur_ff.op == DPVD_OP_REFRESH) begin
          if (tdone(tmr_ff, DPVD_TRAS_CYC)) begin
            nxt_pins.ras_n = 1'b1;
            nxt_st = DPVD_S_PRE;
            nxt_tmr = 16'h0000;
          end
        end else if (tmr_ff == 16'h0002) begin
          nxt_pins.cas_n = 1'b0; // column latched on cas fall
          nxt_st = DPVD_S_CAS;
          nxt_tmr = 16'h0000;
        end
      end
      DPVD_S_CAS: begin
        if (tdone(tmr_ff, DPVD_TCAS_CYC)) begin
          nxt_tmr = 16'h0000;
          if (cur_ff.op == DPVD_OP_READ || cur_ff.op == DPVD_OP_RMW) begin
            nxt_rdata = dq_s_ff; // data settled well before this point
            nxt_rvld = (cur_ff.op == DPVD_OP_READ);
          end
          if (cur_ff.op == DPVD_OP_RMW) begin
            // read first, then drive data and drop we late
            nxt_pins.tr_oe_n = 1'b1;
            nxt_pins.dq_o = cur_ff.wdata;
            nxt_pins.dq_oe = 1'b1;
            nxt_st = DPVD_S_LATE;
          end else if (cur_ff.op == DPVD_OP_XFER) begin
            nxt_st = DPVD_S_XEND;
          end else begin
            nxt_pins.cas_n = 1'b1; // read command held past cas rise
            nxt_pins.ras_n = 1'b1;
            nxt_st = DPVD_S_PRE;
          end
        end
      end
      DPVD_S_LATE: begin
        nxt_pins.we_n = 1'b0; // data taken on we fall
        if (tdone(tmr_ff, 2)) begin
          nxt_pins.we_n = 1'b1;
          nxt_pins.cas_n = 1'b1;
          nxt_pins.ras_n = 1'b1;
          nxt_rvld = 1'b1;
          nxt_st = DPVD_S_PRE;
          nxt_tmr = 16'h0000;
        end
      end
      DPVD_S_XEND: begin
        // transfer hold depends on serial state
        if (tdone(tmr_ff, ser_active ? DPVD_TRDH_CYC : DPVD_TRDH1_CYC)) begin
          nxt_pins.tr_oe_n = 1'b1;
          nxt_pins.cas_n = 1'b1;
          nxt_pins.ras_n = 1'b1;
          nxt_st = DPVD_S_PRE;
          nxt_tmr = 16'h0000;
        end
      end
      DPVD_S_PRE: begin
        nxt_pins.ras_n = 1'b1;
        nxt_pins.cas_n = 1'b1;
        nxt_pins.we_n = 1'b1;
        nxt_pins.tr_oe_n = 1'b1;
        nxt_pins.dq_oe = 1'b0;
        if (tdone(tmr_ff, DPVD_TRP_CYC)) begin
          nxt_tmr = 16'h0000;
          if (cur_ff.op == DPVD_OP_REFRESH) begin
            nxt_ref_row = ref_row_ff + 9'h001;
          end
          if (!init_done_ff) begin
            nxt_init_cnt = init_cnt_ff + 4'h1;
            if (init_cnt_ff == 4'(DPVD_INIT_RAS - 1)) begin
              nxt_init = 1'b1;
              nxt_st = DPVD_S_IDLE;
            end else begin
              nxt_pins.addr = ref_row_ff + 9'h001;
              nxt_st = DPVD_S_RAS;
            end
          end else begin
            nxt_st = DPVD_S_IDLE;
          end
        end
      end
      default: nxt_st = DPVD_S_IDLE;
    endcase
    // refresh interval: one row per tick, all 512 within 8 ms
    // placed after the case so a tick beats the clear in idle
    if (init_done_ff) begin
      if (ref_tmr_ff == 16'(REF_INT_CYC - 1)) begin
        nxt_ref_tmr = 16'h0000;
        nxt_ref_due = 1'b1;
      end else begin
        nxt_ref_tmr = ref_tmr_ff + 16'h0001;
      end
    end
  end

  // registers of the sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= DPVD_S_PWRUP;
      tmr_ff <= 16'h0000;
      ref_tmr_ff <= 16'h0000;
      ref_row_ff <= '0;
      ref_due_ff <= 1'b0;
      init_cnt_ff <= 4'h0;
      cur_ff <= '0;
      pins_ff <= '{ras_n: 1'b1, cas_n: 1'b1, tr_oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
      req_ready_ff <= 1'b0;
      rdata_ff <= '0;
      rdata_valid_ff <= 1'b0;
      init_done_ff <= 1'b0;
      soe_n_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      ref_tmr_ff <= nxt_ref_tmr;
      ref_row_ff <= nxt_ref_row;
      ref_due_ff <= nxt_ref_due;
      init_cnt_ff <= nxt_init_cnt;
      cur_ff <= nxt_cur;
      pins_ff <= nxt_pins;
      req_ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
      rdata_valid_ff <= nxt_rvld;
      init_done_ff <= nxt_init;
      soe_n_ff <= ~nxt_init;
    end
  end
endmodule
`default_nettype wire

// >>> core/dpvd_pkg.sv
package dpvd_pkg;

  // ****************************************
  // timing figures and derived cycle counts
  // ****************************************
  localparam int unsigned DPVD_CLK_MHZ = 50; // system clock rate
  localparam int unsigned DPVD_PWRUP_US = 100; // power-up pause
  localparam int unsigned DPVD_PWRUP_CYC = DPVD_PWRUP_US * DPVD_CLK_MHZ; // 5000 cycles
  localparam int unsigned DPVD_REF_MS = 8; // refresh window
  localparam int unsigned DPVD_REF_ROWS = 512; // rows to refresh in window
  localparam int unsigned DPVD_REF_INT_CYC = (DPVD_REF_MS * 1000 * DPVD_CLK_MHZ) / DPVD_REF_ROWS; // 781, round down
  localparam int unsigned DPVD_INIT_RAS = 8; // wake-up ras cycles
  localparam int unsigned DPVD_TRC_NS = 190; // random cycle time
  localparam int unsigned DPVD_TRAS_NS = 100; // ras pulse width
  localparam int unsigned DPVD_TRP_NS = 80; // ras precharge
  localparam int unsigned DPVD_TCAS_NS = 50; // cas pulse width
  localparam int unsigned DPVD_TRDH_NS = 80; // transfer hold, serial active
  localparam int unsigned DPVD_TRDH1_NS = 15; // transfer hold, serial standby
  localparam int unsigned DPVD_TCLK_NS = 1000 / DPVD_CLK_MHZ; // 20 ns
  localparam int unsigned DPVD_TRAS_CYC = (DPVD_TRAS_NS + DPVD_TCLK_NS - 1) / DPVD_TCLK_NS; // 5
  localparam int unsigned DPVD_TRP_CYC = (DPVD_TRP_NS + DPVD_TCLK_NS - 1) / DPVD_TCLK_NS; // 4
  localparam int unsigned DPVD_TCAS_CYC = (DPVD_TCAS_NS + DPVD_TCLK_NS - 1) / DPVD_TCLK_NS; // 3
  localparam int unsigned DPVD_TRDH_CYC = (DPVD_TRDH_NS + DPVD_TCLK_NS - 1) / DPVD_TCLK_NS; // 4
  localparam int unsigned DPVD_TRDH1_CYC = (DPVD_TRDH1_NS + DPVD_TCLK_NS - 1) / DPVD_TCLK_NS; // 1
  localparam int unsigned DPVD_SC_HALF_CYC = 2; // serial strobe half period, 40 ns

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned DPVD_AW = 9; // muxed address width
  localparam int unsigned DPVD_DW = 4; // random and serial data width

  // ****************************************
  // request carried into the controller
  // ****************************************
  typedef enum logic [2:0] {
    DPVD_OP_READ, DPVD_OP_WRITE, DPVD_OP_RMW, DPVD_OP_XFER, DPVD_OP_REFRESH
  } dpvd_op_t;

  typedef struct packed {
    dpvd_op_t op; // kind of cycle
    logic [DPVD_AW-1:0] row; // row address
    logic [DPVD_AW-1:0] col; // column or serial start
    logic [DPVD_DW-1:0] wdata; // write data
    logic [DPVD_DW-1:0] mask; // bits to write, ones written
    logic use_mask; // write-per-bit cycle
  } dpvd_req_t;

  // pins of the random port as driven out
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic tr_oe_n;
    logic we_n;
    logic [DPVD_AW-1:0] addr;
    logic [DPVD_DW-1:0] dq_o;
    logic dq_oe;
  } dpvd_pins_t;

endpackage

// >>> core/dpvd_serial.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial strobe generator
// ****************************************
module dpvd_serial
  import dpvd_pkg::*;
#(
  parameter int unsigned HALF = DPVD_SC_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run, // request shifting
  input wire logic [DPVD_DW-1:0] sdata_s, // synchronised serial data
  output logic sc_ff, // serial strobe pin
  output logic active_ff, // serial port not in standby
  output logic [DPVD_DW-1:0] nib_ff, // last nibble captured
  output logic nib_vld_ff // one-cycle pulse per nibble
);
  logic [7:0] cnt_ff, nxt_cnt; // half-period counter
  logic nxt_sc, nxt_active, nxt_vld;
  logic grab_ff, nxt_grab; // strobe fell last edge, nibble due at the synchroniser
  logic [DPVD_DW-1:0] nxt_nib;

  // strobe rises give next nibble; take it one cycle after the fall
  // the pin needs two edges through the synchroniser, so half must be 2 or more
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_sc = sc_ff;
    nxt_active = run;
    nxt_nib = nib_ff;
    nxt_vld = 1'b0;
    nxt_grab = 1'b0;
    if (run || sc_ff) begin
      if (cnt_ff == 8'(HALF - 1)) begin
        nxt_cnt = 8'h00;
        nxt_sc = ~sc_ff & run;
        nxt_grab = sc_ff; // falling now
      end else begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
    // synchroniser output now holds the nibble launched by the last rise
    if (grab_ff) begin
      nxt_nib = sdata_s;
      nxt_vld = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      sc_ff <= 1'b0;
      active_ff <= 1'b0;
      nib_ff <= '0;
      nib_vld_ff <= 1'b0;
      grab_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      sc_ff <= nxt_sc;
      active_ff <= nxt_active;
      nib_ff <= nxt_nib;
      nib_vld_ff <= nxt_vld;
      grab_ff <= nxt_grab;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/dpvd_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// controller pin checks
// ****************
module dpvd_ctrl_properties
  import dpvd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire dpvd_req_t req,
  input wire logic req_ready_ff,
  input wire logic rdata_valid_ff,
  input wire logic init_done_ff,
  input wire dpvd_pins_t pins_ff,
  input wire logic sc_out,
  input wire logic soe_n_ff
);
  logic ras_q_ff, nxt_ras_q; // ras level last cycle
  logic [3:0] wake_cnt_ff, nxt_wake_cnt; // ras falls before init ends
  // count row strobe falls of the wake-up phase
  always_comb begin
    nxt_ras_q = pins_ff.ras_n;
    nxt_wake_cnt = wake_cnt_ff;
    if (ras_q_ff && !pins_ff.ras_n && !init_done_ff) begin
      nxt_wake_cnt = wake_cnt_ff + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      ras_q_ff <= 1'b1;
      wake_cnt_ff <= 4'h0;
    end else begin
      ras_q_ff <= nxt_ras_q;
      wake_cnt_ff <= nxt_wake_cnt;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_NO_TAKE_EARLY: assert property (!init_done_ff |-> !req_ready_ff)
    else $error("request taken before wake-up");
  AST_WAKE_EIGHT: assert property ($rose(init_done_ff) |-> wake_cnt_ff == 4'h8)
    else $error("wake-up ras count wrong");
  AST_WAKE_NO_CBR: assert property (!init_done_ff && $fell(pins_ff.ras_n) |-> pins_ff.cas_n)
    else $error("cas low at wake-up ras fall");
  AST_READ_HOLD: assert property ($rose(pins_ff.cas_n) && $past(pins_ff.we_n) && !$past(pins_ff.ras_n)
    |-> pins_ff.we_n)
    else $error("read command dropped before cas rise");
  AST_XFER_CAS_HIGH: assert property ($fell(pins_ff.ras_n) && !pins_ff.tr_oe_n |-> pins_ff.cas_n)
    else $error("transfer start with cas low");
  AST_WPB_MASK: assert property ($fell(pins_ff.ras_n) && !pins_ff.we_n && pins_ff.tr_oe_n
    |-> pins_ff.cas_n && pins_ff.dq_oe)
    else $error("bit mask not on bus at ras fall");
  AST_XFER_HOLD: assert property ($fell(pins_ff.ras_n) && !pins_ff.tr_oe_n && sc_out != $past(sc_out, 2)
    |-> !pins_ff.tr_oe_n [*4])
    else $error("transfer input released early while shifting");
  AST_SOE_LOW: assert property (init_done_ff |-> !soe_n_ff)
    else $error("serial output enable high after init");
  AST_READ_ANSWER: assert property (req_ready_ff && $past(req.op) == DPVD_OP_READ
    |-> ##[1:16] rdata_valid_ff)
    else $error("read data not returned");
  COV_XFER: cover property ($fell(pins_ff.ras_n) && !pins_ff.tr_oe_n);
  COV_WPB: cover property ($fell(pins_ff.ras_n) && !pins_ff.we_n && pins_ff.tr_oe_n);
  COV_READ: cover property (rdata_valid_ff);
endmodule
bind dpvd_ctrl dpvd_ctrl_properties u_props (
  .clk(clk), .rst(rst), .req(req), .req_ready_ff(req_ready_ff),
  .rdata_valid_ff(rdata_valid_ff), .init_done_ff(init_done_ff),
  .pins_ff(pins_ff), .sc_out(sc_out), .soe_n_ff(soe_n_ff)
);
`default_nettype wire

// >>> testbench/dpvd_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// behavioural buffer device
// ****************
module dpvd_dev_model
  import dpvd_pkg::*;
(
  input wire dpvd_pins_t p,
  input wire logic [3:0] dq_w,
  input wire logic sc,
  input wire logic soe_n,
  output logic [3:0] dq_d,
  output logic [3:0] so
);
  logic [3:0] mem [bit [17:0]] = '{default: 4'h0}; // sparse array
  logic [3:0] sreg [512] = '{default: 4'h0}; // row data register
  logic [8:0] row, col, ptr; // latched addresses, serial pointer
  logic [3:0] msk, sv; // write mask, last nibble
  logic xfer = 1'b0; // transfer cycle open
  logic [8:0] cbr_row = 9'h0; // internal refresh row counter
  wire rd = !p.ras_n && !p.cas_n && !xfer && p.we_n && !p.tr_oe_n; // output on
  initial dq_d = 4'h0;
  initial sv = 4'h0;
  initial ptr = 9'h0;
  // ras fall picks cycle kind; cas-first only refreshes
  always @(negedge p.ras_n) begin
    #1;
    row = p.addr;
    // cas already low: row comes from the internal counter
    if (!p.cas_n) begin
      row = cbr_row;
      cbr_row = cbr_row + 9'h1;
    end
    xfer = p.cas_n && !p.tr_oe_n;
    msk = (p.cas_n && p.tr_oe_n && !p.we_n) ? dq_w : 4'hf;
  end
  task automatic wr;
    mem[{row, col}] = (mem[{row, col}] & ~msk) | (dq_w & msk);
  endtask
  // early write on cas fall
  always @(negedge p.cas_n) begin
    col = p.addr;
    #1;
    if (!p.ras_n && !xfer && !p.we_n) wr();
  end
  // late write and read-modify-write on we fall
  always @(negedge p.we_n) begin
    #1;
    if (!p.ras_n && !p.cas_n && !xfer) wr();
  end
  // drive read data; released bus shows inverse, not a kind value
  always @(posedge rd) #1 dq_d = mem[{row, col}];
  always @(negedge rd) dq_d = ~dq_d;
  // rising transfer input copies row and sets start
  always @(posedge p.tr_oe_n) begin
    if (xfer) begin
      for (int i = 0; i < 512; i++) sreg[i] = mem[{row, 9'(i)}];
      ptr = col;
      xfer = 1'b0;
    end
  end
  // serial strobe rise gives next nibble
  always @(posedge sc) begin
    sv = sreg[ptr];
    ptr = ptr + 9'h1;
  end
  assign so = soe_n ? ~sv : sv;
endmodule
`default_nettype wire

// >>> testbench/tb_dual_port_video_dram.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_port_video_dram;
  import dpvd_pkg::*;
  logic clk, rst, req_valid, shift_run, req_ready_ff, rdata_valid_ff, init_done_ff;
  logic sdata_valid_ff, sc_out, soe_n_ff;
  dpvd_req_t req; // request to controller
  dpvd_pins_t pins_ff; // random port pins
  logic [3:0] rdata_ff, sdata_ff, dq_i, so_i, dev_dq;
  logic [7:0] nras; // ras falls seen
  int miscompares, n_tests;
  assign dq_i = pins_ff.dq_oe ? pins_ff.dq_o : dev_dq; // resolved data bus
  dpvd_ctrl #(.PWRUP_CYC(20), .REF_INT_CYC(50)) uut (
    .clk(clk), .rst(rst), .req(req), .req_valid(req_valid), .req_ready_ff(req_ready_ff),
    .rdata_ff(rdata_ff), .rdata_valid_ff(rdata_valid_ff), .init_done_ff(init_done_ff),
    .shift_run(shift_run), .sdata_ff(sdata_ff), .sdata_valid_ff(sdata_valid_ff),
    .pins_ff(pins_ff), .dq_i(dq_i), .sc_out(sc_out), .soe_n_ff(soe_n_ff), .so_i(so_i));
  dpvd_dev_model dev (.p(pins_ff), .dq_w(dq_i), .sc(sc_out), .soe_n(soe_n_ff), .dq_d(dev_dq), .so(so_i));
  always @(negedge pins_ff.ras_n) nras <= nras + 8'h1;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // offer one request and wait for it to be taken
  task automatic put(input dpvd_op_t k, input logic [8:0] r, c, input logic [3:0] d, m, input logic u);
    int w;
    req = '{k, r, c, d, m, u};
    req_valid = 1'b1;
    w = 0;
    do begin
      tick(1);
      w++;
    end while (req_ready_ff !== 1'b1 && w < 300);
    req_valid = 1'b0;
    check({3'h0, req_ready_ff}, 4'h1);
    tick(1);
  endtask
  task automatic take(input logic [3:0] e);
    int w;
    w = 0;
    while (rdata_valid_ff !== 1'b1 && w < 40) begin
      tick(1);
      w++;
    end
    check({3'h0, rdata_valid_ff}, 4'h1);
    check(rdata_ff, e);
  endtask
  task automatic nib(output logic [3:0] v);
    int w;
    w = 0;
    while (sdata_valid_ff !== 1'b1 && w < 40) begin
      tick(1);
      w++;
    end
    v = (w < 40) ? sdata_ff : 4'hx;
    tick(1);
  endtask
  task automatic t_init;
    int w;
    w = 0;
    while (init_done_ff !== 1'b1 && w < 2000) begin
      tick(1);
      w++;
    end
    check({3'h0, init_done_ff}, 4'h1);
    check(nras[3:0], 4'h8);
    check({3'h0, soe_n_ff}, 4'h0);
    $display("test init done");
  endtask
  // back-to-back writes, masked write, read-modify-write
  task automatic t_random;
    put(DPVD_OP_WRITE, 9'h1, 9'h5, 4'ha, 4'hf, 1'b0);
    put(DPVD_OP_WRITE, 9'h1, 9'h6, 4'h3, 4'hf, 1'b0);
    put(DPVD_OP_WRITE, 9'h1, 9'h7, 4'hc, 4'hf, 1'b0);
    put(DPVD_OP_WRITE, 9'h2, 9'h9, 4'ha, 4'hf, 1'b0);
    put(DPVD_OP_WRITE, 9'h2, 9'ha, 4'h7, 4'hf, 1'b0);
    put(DPVD_OP_READ, 9'h1, 9'h6, 4'h0, 4'hf, 1'b0);
    take(4'h3);
    put(DPVD_OP_WRITE, 9'h2, 9'h9, 4'h5, 4'h3, 1'b1);
    put(DPVD_OP_READ, 9'h2, 9'h9, 4'h0, 4'hf, 1'b0);
    take(4'h9);
    put(DPVD_OP_RMW, 9'h2, 9'h9, 4'h6, 4'hf, 1'b0);
    take(4'h9);
    put(DPVD_OP_READ, 9'h2, 9'h9, 4'h0, 4'hf, 1'b0);
    take(4'h6);
    $display("test random port done");
  endtask
  // transfer in standby, then shift the new row
  task automatic t_xfer_idle;
    logic [3:0] v;
    put(DPVD_OP_XFER, 9'h1, 9'h5, 4'h0, 4'hf, 1'b0);
    put(DPVD_OP_READ, 9'h1, 9'h5, 4'h0, 4'hf, 1'b0);
    take(4'ha);
    shift_run = 1'b1;
    nib(v);
    check(v, 4'ha);
    nib(v);
    check(v, 4'h3);
    nib(v);
    check(v, 4'hc);
    $display("test transfer standby done");
  endtask
  // transfer while shifting: output moves to the new row
  task automatic t_xfer_live;
    logic [3:0] v;
    logic hit;
    hit = 1'b0;
    put(DPVD_OP_XFER, 9'h2, 9'h9, 4'h0, 4'hf, 1'b0);
    for (int i = 0; i < 60 && !hit; i++) begin
      nib(v);
      hit = (v === 4'h6);
    end
    nib(v);
    check({3'h0, hit}, 4'h1);
    check(v, 4'h7);
    shift_run = 1'b0;
    $display("test transfer active done");
  endtask
  task automatic t_refresh;
    logic [7:0] n0;
    n0 = nras;
    tick(200);
    check({3'h0, (nras - n0) >= 8'd3}, 4'h1);
    $display("test refresh done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    req_valid = 1'b0;
    shift_run = 1'b0;
    nras = 8'h0;
    miscompares = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    #2;
    rst = 1'b0;
    t_init();
    t_random();
    t_xfer_idle();
    t_xfer_live();
    t_refresh();
    close_out();
  end
endmodule
`default_nettype wire
